// ==== hdl/pbseq_params.svh ====
`ifndef PBSEQ_PARAMS_SVH
`define PBSEQ_PARAMS_SVH

// Clock period in picoseconds
`define PBSEQ_CLK_PS         4000
// Timer base tick in microseconds
`define PBSEQ_TICK_US        1000
// Derived cycles per millisecond tick
`define PBSEQ_TICK_CYC       ((`PBSEQ_TICK_US * 1000000) / `PBSEQ_CLK_PS)
`define PBSEQ_DB_BASE_MS     32
`define PBSEQ_EXT_FIXED_MS   1
`define PBSEQ_BLANK_MS       512
`define PBSEQ_PD_MS          1024
`define PBSEQ_LOCK_MS        256
`define PBSEQ_REL_DB_MS      32
// Kill glitch filter, least time rounds up
`define PBSEQ_KILL_PW_NS     30000
`define PBSEQ_KILL_PW_CYC    ((`PBSEQ_KILL_PW_NS * 1000 + `PBSEQ_CLK_PS - 1) / `PBSEQ_CLK_PS)
`define PBSEQ_EXT_W          8
`define PBSEQ_MS_W           11
`define PBSEQ_EN_ACT_HIGH    1'b1

`endif

// ==== hdl/pbseq_pkg.sv ====
package pbseq_pkg;
    typedef enum logic [6:0] {
        PBSEQ_OFF      = 7'b000_0001,
        PBSEQ_ON_DB    = 7'b000_0010,
        PBSEQ_BLANK    = 7'b000_0100,
        PBSEQ_REL_DB   = 7'b000_1000,
        PBSEQ_RUN      = 7'b001_0000,
        PBSEQ_OFF_DB   = 7'b010_0000,
        PBSEQ_PD_WAIT  = 7'b100_0000
    } pbseq_state_type;
endpackage : pbseq_pkg

// ==== hdl/pbseq_tick.sv ====
`timescale 1ns/1ps
`include "pbseq_params.svh"

// Free-running prescaler giving one pulse per timer tick
module pbseq_tick #(
    parameter int TICK_CYC = `PBSEQ_TICK_CYC
) (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    output logic      tick_o
);
    localparam int W = $clog2(TICK_CYC + 1);

    initial
    begin
        if (TICK_CYC < 2)
            $error("pbseq_tick: TICK_CYC must be at least 2");
    end

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         tick_r;
    logic         tick_nxt;

    always_comb
    begin
        tick_nxt = (cnt_r == W'(TICK_CYC - 1));
        cnt_nxt  = tick_nxt ? '0 : cnt_r + W'(1);
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule : pbseq_tick

// ==== hdl/pbseq_top.sv ====
`timescale 1ns/1ps
`include "pbseq_params.svh"

module pbseq_top #(
    parameter logic                 EN_ACT_HIGH = `PBSEQ_EN_ACT_HIGH,
    parameter int                   TICK_CYC    = `PBSEQ_TICK_CYC,
    parameter int                   KILL_CYC    = `PBSEQ_KILL_PW_CYC,
    parameter int                   EXT_W       = `PBSEQ_EXT_W
) (
    input  wire logic               mclk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               pushbutton_n_i,
    input  wire logic               kill_n_i,
    input  wire logic [EXT_W-1:0]   on_time_extend_i,
    input  wire logic [EXT_W-1:0]   off_time_extend_i,
    output logic                    power_en_o,
    output logic                    pwr_down_req_n_o
);
    import pbseq_pkg::*;

    localparam int MW = `PBSEQ_MS_W;
    localparam int KW = $clog2(KILL_CYC + 1);

    initial
    begin
        if (EXT_W < 1 || EXT_W > 10)
            $error("pbseq_top: EXT_W out of range 1..10");
        if (KILL_CYC < 1)
            $error("pbseq_top: KILL_CYC must be positive");
        if (TICK_CYC < 2)
            $error("pbseq_top: TICK_CYC must be at least 2");
    end

    // Debounce length in ticks; an extension of zero means the bare base
    function automatic logic [MW-1:0] db_len(input logic [EXT_W-1:0] ext);
        logic [MW-1:0] len;
        len = MW'(`PBSEQ_DB_BASE_MS);
        if (ext != '0)
            len = len + MW'(`PBSEQ_EXT_FIXED_MS) + MW'(ext);
        return len;
    endfunction : db_len

    logic tick;

    pbseq_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .tick_o    (tick)
    );

    // Kill filter: only lows lasting the full width count
    logic [KW-1:0] kcnt_r;
    logic [KW-1:0] kcnt_nxt;
    logic          kill_r;
    logic          kill_nxt;

    always_comb
    begin
        kcnt_nxt = kcnt_r;
        kill_nxt = kill_r;
        if (kill_n_i)
        begin
            kcnt_nxt = '0;
            kill_nxt = 1'b0;
        end
        else if (kcnt_r == KW'(KILL_CYC - 1))
            kill_nxt = 1'b1;
        else
            kcnt_nxt = kcnt_r + KW'(1);
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            kcnt_r <= '0;
            kill_r <= 1'b0;
        end
        else
        begin
            kcnt_r <= kcnt_nxt;
            kill_r <= kill_nxt;
        end
    end

    // Main sequencer
    pbseq_state_type st_r;
    pbseq_state_type st_nxt;
    logic [MW-1:0]   tmr_r;
    logic [MW-1:0]   tmr_nxt;
    logic [MW-1:0]   lock_r;
    logic [MW-1:0]   lock_nxt;
    logic            pb_q_r;
    logic            pb_q_nxt;
    logic            en_r;
    logic            en_nxt;
    logic            req_n_r;
    logic            req_n_nxt;
    logic            release_now;

    always_comb
    begin
        st_nxt      = st_r;
        tmr_nxt     = tmr_r;
        lock_nxt    = lock_r;
        pb_q_nxt    = pushbutton_n_i;
        en_nxt      = en_r;
        req_n_nxt   = req_n_r;
        release_now = 1'b0;
        if (tick && lock_r != '0)
            lock_nxt = lock_r - MW'(1);
        case (st_r)
            PBSEQ_OFF:
            begin
                // Falling edge only; a button held through lockout must be let go first
                if (lock_r == '0 && pb_q_r && !pushbutton_n_i)
                begin
                    st_nxt  = PBSEQ_ON_DB;
                    tmr_nxt = '0;
                end
            end
            PBSEQ_ON_DB:
            begin
                if (pushbutton_n_i)
                begin
                    st_nxt  = PBSEQ_OFF;
                    tmr_nxt = '0;
                end
                else if (tick)
                begin
                    if (tmr_r + MW'(1) >= db_len(on_time_extend_i))
                    begin
                        st_nxt  = PBSEQ_BLANK;
                        en_nxt  = 1'b1;
                        tmr_nxt = '0;
                    end
                    else
                        tmr_nxt = tmr_r + MW'(1);
                end
            end
            PBSEQ_BLANK:
            begin
                // Inputs are not looked at until the window closes
                if (tick)
                begin
                    if (tmr_r + MW'(1) >= MW'(`PBSEQ_BLANK_MS))
                    begin
                        tmr_nxt = '0;
                        if (kill_r)
                            release_now = 1'b1;
                        else
                            st_nxt = PBSEQ_REL_DB;
                    end
                    else
                        tmr_nxt = tmr_r + MW'(1);
                end
            end
            PBSEQ_REL_DB:
            begin
                if (kill_r)
                    release_now = 1'b1;
                else if (!pushbutton_n_i)
                    tmr_nxt = '0;
                else if (tick)
                begin
                    if (tmr_r + MW'(1) >= MW'(`PBSEQ_REL_DB_MS))
                    begin
                        st_nxt  = PBSEQ_RUN;
                        tmr_nxt = '0;
                    end
                    else
                        tmr_nxt = tmr_r + MW'(1);
                end
            end
            PBSEQ_RUN:
            begin
                if (kill_r)
                    release_now = 1'b1;
                else if (pb_q_r && !pushbutton_n_i)
                begin
                    st_nxt  = PBSEQ_OFF_DB;
                    tmr_nxt = '0;
                end
            end
            PBSEQ_OFF_DB:
            begin
                if (kill_r)
                    release_now = 1'b1;
                else if (pushbutton_n_i)
                begin
                    st_nxt  = PBSEQ_RUN;
                    tmr_nxt = '0;
                end
                else if (tick)
                begin
                    if (tmr_r + MW'(1) >= db_len(off_time_extend_i))
                    begin
                        st_nxt    = PBSEQ_PD_WAIT;
                        req_n_nxt = 1'b0;
                        tmr_nxt   = '0;
                    end
                    else
                        tmr_nxt = tmr_r + MW'(1);
                end
            end
            PBSEQ_PD_WAIT:
            begin
                if (kill_r)
                    release_now = 1'b1;
                else if (tick)
                begin
                    if (tmr_r + MW'(1) >= MW'(`PBSEQ_PD_MS))
                        release_now = 1'b1;
                    else
                        tmr_nxt = tmr_r + MW'(1);
                end
            end
            default:
            begin
                st_nxt = PBSEQ_OFF;
                en_nxt = 1'b0;
            end
        endcase
        if (release_now)
        begin
            st_nxt    = PBSEQ_OFF;
            en_nxt    = 1'b0;
            req_n_nxt = 1'b1;
            tmr_nxt   = '0;
            lock_nxt  = MW'(`PBSEQ_LOCK_MS);
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_r    <= PBSEQ_OFF;
            tmr_r   <= '0;
            lock_r  <= '0;
            pb_q_r  <= 1'b1;
            en_r    <= 1'b0;
            req_n_r <= 1'b1;
        end
        else
        begin
            st_r    <= st_nxt;
            tmr_r   <= tmr_nxt;
            lock_r  <= lock_nxt;
            pb_q_r  <= pb_q_nxt;
            en_r    <= en_nxt;
            req_n_r <= req_n_nxt;
        end
    end

    // Polarity folded into the flop so the pin stays glitch-free
    logic pen_r;
    logic pen_nxt;

    always_comb
    begin
        pen_nxt = EN_ACT_HIGH ? en_nxt : ~en_nxt;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pen_r <= ~EN_ACT_HIGH;
        else
            pen_r <= pen_nxt;
    end

    assign power_en_o       = pen_r;
    assign pwr_down_req_n_o = req_n_r;
endmodule : pbseq_top

// ==== tb/pbseq_host.sv ====
`timescale 1ns/1ps
module pbseq_host (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        en_i,
    input  wire logic        req_n_i,
    input  wire logic        press_i,
    input  wire logic        boot_ok_i,
    input  wire logic        kill_cmd_i,
    input  wire logic [31:0] sd_dly_i,
    output logic             pushbutton_n_o,
    output logic             kill_n_o
);
    logic [31:0] cnt_r;
    logic        up_r;
    assign pushbutton_n_o = !press_i;
    // An unpowered processor cannot hold kill high
    assign kill_n_o = up_r && !kill_cmd_i && (req_n_i || cnt_r < sd_dly_i);
    always_ff @(posedge mclk_i or posedge sys_rst_i)
        if (sys_rst_i)
        begin
            cnt_r <= '0;
            up_r  <= 1'b0;
        end
        else
        begin
            cnt_r <= req_n_i ? '0 : cnt_r + 1;
            up_r  <= en_i && boot_ok_i;
        end
endmodule : pbseq_host

// ==== tb/pbseq_props.sv ====
`timescale 1ns/1ps
module pbseq_props #(
    parameter logic EN_ACT_HIGH = 1'b1,
    parameter int   TICK_CYC    = 10,
    parameter int   KILL_CYC    = 3,
    parameter int   EXT_W       = 8
) (
    input wire logic             mclk_i,
    input wire logic             sys_rst_i,
    input wire logic             pushbutton_n_i,
    input wire logic             kill_n_i,
    input wire logic [EXT_W-1:0] on_time_extend_i,
    input wire logic [EXT_W-1:0] off_time_extend_i,
    input wire logic             power_en_o,
    input wire logic             pwr_down_req_n_o
);
    logic [31:0] pb_r, kl_r, on_r, off_r, rq_r;
    int          lon, loff;
    wire         en = power_en_o == EN_ACT_HIGH;
    assign lon  = on_time_extend_i == 0 ? 32 : 33 + on_time_extend_i;
    assign loff = off_time_extend_i == 0 ? 32 : 33 + off_time_extend_i;
    // Run lengths; off_r starts saturated so the first turn-on is not held back
    always_ff @(posedge mclk_i or posedge sys_rst_i)
        if (sys_rst_i)
        begin
            pb_r  <= '0;
            kl_r  <= '0;
            on_r  <= '0;
            rq_r  <= '0;
            off_r <= 32'h00ff_ffff;
        end
        else
        begin
            pb_r  <= pushbutton_n_i ? '0 : pb_r + 1;
            kl_r  <= kill_n_i ? '0 : kl_r + 1;
            on_r  <= en ? on_r + 1 : '0;
            rq_r  <= pwr_down_req_n_o ? '0 : rq_r + 1;
            off_r <= en ? '0 : off_r + 32'(off_r < 32'h00ff_ffff);
        end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    rst_rel_a: assert property ($fell(sys_rst_i) |-> !en && pwr_down_req_n_o)
        else $error("output active after reset");
    on_time_a: assert property ($rose(en) |-> pb_r >= (lon - 1) * TICK_CYC && pb_r <= lon * TICK_CYC + 6)
        else $error("turn-on debounce length wrong");
    off_time_a: assert property ($fell(pwr_down_req_n_o) |-> pb_r >= (loff - 1) * TICK_CYC && pb_r <= loff * TICK_CYC + 6)
        else $error("turn-off debounce length wrong");
    req_hold_a: assert property (!pwr_down_req_n_o |-> en)
        else $error("request low while released");
    pd_limit_a: assert property (rq_r <= 1024 * TICK_CYC + 6)
        else $error("power-down deadline overrun");
    kill_rel_a: assert property (!pwr_down_req_n_o && kl_r == KILL_CYC |-> ##[1:4] (!en && pwr_down_req_n_o))
        else $error("kill did not release enable");
    kill_glitch_a: assert property (en && kill_n_i && kl_r != 0 && kl_r < KILL_CYC |=> en [*4])
        else $error("short kill pulse released enable");
    blank_window_a: assert property ($fell(en) |-> on_r >= 511 * TICK_CYC)
        else $error("release inside blanking");
    press_lockout_a: assert property ($rose(en) |-> off_r >= (lon + 254) * TICK_CYC)
        else $error("turn-on inside lockout");
endmodule : pbseq_props

bind pbseq_top pbseq_props #(.EN_ACT_HIGH(EN_ACT_HIGH), .TICK_CYC(TICK_CYC),
    .KILL_CYC(KILL_CYC), .EXT_W(EXT_W)) pbseq_props_i (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .pushbutton_n_i(pushbutton_n_i), .kill_n_i(kill_n_i),
    .on_time_extend_i(on_time_extend_i), .off_time_extend_i(off_time_extend_i),
    .power_en_o(power_en_o), .pwr_down_req_n_o(pwr_down_req_n_o));

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam int T = 10;
    localparam int K = 3;
    logic        mclk_i = 0, sys_rst_i = 1, press = 0, boot_ok = 0, kill_cmd = 0;
    logic [7:0]  on_ext = 0, off_ext = 0;
    logic [31:0] sd_dly = 0;
    logic        pb_n, kill_n, power_en, req_n, power_en_lo, req_n_lo;
    int          bad_count = 0, checked = 0, cyc = 0, n, l;
    integer      seed = 32'h7bfdcfef;
    pbseq_top #(.TICK_CYC(T), .KILL_CYC(K)) pbseq_top_i (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .pushbutton_n_i(pb_n), .kill_n_i(kill_n),
        .on_time_extend_i(on_ext), .off_time_extend_i(off_ext),
        .power_en_o(power_en), .pwr_down_req_n_o(req_n));
    pbseq_top #(.EN_ACT_HIGH(1'b0), .TICK_CYC(T), .KILL_CYC(K)) pbseq_top_lo_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pushbutton_n_i(pb_n), .kill_n_i(kill_n),
        .on_time_extend_i(on_ext), .off_time_extend_i(off_ext),
        .power_en_o(power_en_lo), .pwr_down_req_n_o(req_n_lo));
    pbseq_host pbseq_host_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .en_i(power_en),
        .req_n_i(req_n), .press_i(press), .boot_ok_i(boot_ok), .kill_cmd_i(kill_cmd),
        .sd_dly_i(sd_dly), .pushbutton_n_o(pb_n), .kill_n_o(kill_n));
    initial
        forever #2 mclk_i = ~mclk_i;
    task automatic tally_and_finish();
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string s, input int lo, input int hi, input int seen);
        checked++;
        if (seen < lo || seen > hi)
        begin
            bad_count++;
            $display("BAD %s expected %0d..%0d seen %0d", s, lo, hi, seen);
        end
    endtask : chk
    task automatic tk(input int c);
        repeat (c) @(posedge mclk_i);
    endtask : tk
    // n counts cycles until the output shows v, hi + 1 if it never does
    task automatic wait_for(input bit on_req, input logic v, input int hi);
        n = 0;
        while (n <= hi && (on_req ? req_n : power_en) !== v)
        begin
            @(posedge mclk_i);
            n++;
        end
    endtask : wait_for
    task automatic boot();
        on_ext <= 8'($random(seed) & 3);
        tk(1);
        l = on_ext == 0 ? 32 : 33 + on_ext;
        press <= 1'b1;
        wait_for(0, 1'b1, 40 * T);
        chk("turn_on", (l - 1) * T, l * T + 6, n);
        tk(100 * T);
        press <= 1'b0;
        wait_for(0, 1'b0, 700 * T);
        chk("enable_kept", 700 * T + 1, 700 * T + 1, n);
        $display("boot done");
    endtask : boot
    task automatic turn_off(input int dly);
        off_ext <= 8'($random(seed) & 3);
        sd_dly  <= dly;
        press   <= 1'b1;
        tk(10 * T);
        press <= 1'b0;
        tk(5 * T);
        l = off_ext == 0 ? 32 : 33 + off_ext;
        press <= 1'b1;
        wait_for(1, 1'b0, 40 * T);
        chk("turn_off", (l - 1) * T, l * T + 6, n);
        press <= 1'b0;
        wait_for(0, 1'b0, 1100 * T);
        chk("req_released", 1, 1, int'(req_n === 1'b1));
    endtask : turn_off
    always @(posedge mclk_i)
    begin
        cyc++;
        if (!sys_rst_i && (power_en_lo !== ~power_en || req_n_lo !== req_n))
            chk("polarity", 1, 1, 0);
        if (cyc == 90000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        tk(20);
        sys_rst_i <= 1'b0;
        tk(2);
        chk("reset_state", 1, 1, int'(power_en === 1'b0 && req_n === 1'b1));
        press <= 1'b1;
        tk(10 * T);
        press <= 1'b0;
        wait_for(0, 1'b1, 40 * T);
        chk("short_press", 40 * T + 1, 40 * T + 1, n);
        press <= 1'b1;
        wait_for(0, 1'b1, 40 * T);
        press <= 1'b0;
        wait_for(0, 1'b0, 600 * T);
        chk("abort", 511 * T, 512 * T + K + 6, n);
        press <= 1'b1;
        tk(40 * T);
        press <= 1'b0;
        wait_for(0, 1'b1, 150 * T);
        chk("lockout", 150 * T + 1, 150 * T + 1, n);
        $display("abort and lockout done");
        tk(100 * T);
        boot_ok <= 1'b1;
        boot();
        turn_off(100 * T);
        chk("kill_release", 100 * T - 2, 100 * T + K + 6, n);
        tk(260 * T);
        boot();
        turn_off(2000 * T);
        chk("pd_deadline", 1023 * T, 1024 * T + 6, n);
        tk(260 * T);
        boot();
        kill_cmd <= 1'b1;
        tk(2);
        kill_cmd <= 1'b0;
        wait_for(0, 1'b0, 20);
        chk("kill_glitch", 21, 21, n);
        kill_cmd <= 1'b1;
        wait_for(0, 1'b0, 20);
        chk("kill_run", K, K + 6, n);
        kill_cmd <= 1'b0;
        $display("kill tests done");
        tally_and_finish();
    end
endmodule : tb
